// [rtl/rtcf_core.sv]
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - fast mode corrects every fourth minute, one pulse per second in seconds below n.
// - magnitudes 61 to 64 put the remaining two to five pulses into second 59.
// - each interrupt pulse lasts 1/1024 s, pulses spaced 1/512 s apart.
// - correction shifts 64 Hz, 1 Hz, minute clocks; 4096 Hz stays uncorrected.
// - offset is seven-bit two's complement, +63 to -64; companion bit picks fast mode.
// - with event enable set, each applied correction pulse shows on interrupt output enable; output data stays low.
// - scratch byte at 03h resets to zero and reads back last write.
// - seconds at 04h: stop flag bit 7, bcd tens 6:4, units 3:0.
// - stop flag sets whenever oscillator halts, and resets to one.
// - stop flag stays until host clears; clear fails while oscillator halted.
// - minutes at 05h: bit 7 reads zero, bcd tens and units, resets zero.
// - twelve-hour hours: half-day bit 5, tens bit 4, units 3:0, 7:6 unused.
// - twenty-four-hour hours: tens bits 5:4, units 3:0, resets zero.
// - format select input chooses twelve or twenty-four hour counting.
module rtcf_core #(
   parameter int unsigned STOP_CYCLES = rtcf_pkg::OSC_STOP_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic linkClk,
   input wire logic [7:0] regAddr,
   input wire logic regWrEn,
   input wire logic [7:0] regWrData,
   input wire logic regRdEn,
   output logic [7:0] regRdData,
   input wire logic [6:0] offsetValue,
   input wire logic fastMode,
   input wire logic correctionEventEnable,
   input wire logic hourFormat12,
   output logic intOut,
   output logic intOe,
   output logic oneHzOut,
   output logic timer64Hz,
   output logic minuteTick,
   output logic timer4096Hz
);
   initial
   begin
      if (STOP_CYCLES < 2 || STOP_CYCLES >= (1 << 20))
         $error("STOP_CYCLES out of range");
   end

   function automatic logic [6:0] bcdToBin(input logic [6:0] v);
      bcdToBin = 7'((v[6:4] * 4'd10) + v[3:0]);
   endfunction

   function automatic logic [6:0] bcdInc(input logic [6:0] v);
      bcdInc = (v[3:0] == 4'd9) ? {3'(v[6:4] + 3'd1), 4'd0} : {v[6:4], 4'(v[3:0] + 4'd1)};
   endfunction

   // link domain: reset sync, prescaler, tick toggle
   logic [1:0] linkRstSync_q;
   logic [4:0] prescale_q, prescale_d;
   logic tickToggle_q, tickToggle_d;

   always_ff @(posedge linkClk)
   begin
      linkRstSync_q <= {linkRstSync_q[0], rst_n};
   end

   always_comb
   begin
      prescale_d = (prescale_q == 5'(rtcf_pkg::LINK_DIV - 1)) ? 5'd0 : 5'(prescale_q + 5'd1);
      tickToggle_d = (prescale_q == 5'(rtcf_pkg::LINK_DIV - 1)) ? ~tickToggle_q : tickToggle_q;
   end

   always_ff @(posedge linkClk)
   begin
      if (!linkRstSync_q[1])
      begin
         prescale_q <= 5'd0;
         tickToggle_q <= 1'b0;
      end
      else
      begin
         prescale_q <= prescale_d;
         tickToggle_q <= tickToggle_d;
      end
   end

   assign timer4096Hz = prescale_q[rtcf_pkg::DIV4096_BIT];

   // clk domain: tick crossing
   logic [2:0] tickSync_q;
   logic tickEvt;

   always_ff @(posedge clk)
   begin
      tickSync_q <= {tickSync_q[1:0], tickToggle_q};
   end

   assign tickEvt = tickSync_q[1] ^ tickSync_q[2];

   // oscillator stop watchdog
   logic [19:0] stopCnt_q, stopCnt_d;
   logic stopped_q, stopped_d;

   always_comb
   begin
      stopCnt_d = tickEvt ? 20'd0 : (stopped_q ? stopCnt_q : 20'(stopCnt_q + 20'd1));
      stopped_d = stopped_q;
      if (tickEvt)
         stopped_d = 1'b0;
      else if (stopCnt_q == 20'(STOP_CYCLES - 1))
         stopped_d = 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         stopCnt_q <= 20'd0;
         stopped_q <= 1'b1;
      end
      else
      begin
         stopCnt_q <= stopCnt_d;
         stopped_q <= stopped_d;
      end
   end

   // correction and second length
   logic [6:0] sec_q, sec_d, min_q, min_d;
   logic [5:0] hour_q, hour_d;
   logic [10:0] tick_q, tick_d;
   logic [10:0] secLen;
   logic [6:0] magnitude, secBin, minBin;
   logic [2:0] pulses;
   logic cycleMinute, secEnd, intPulse_q, intPulse_d;
   logic oneHz_q, oneHz_d, hz64_q, hz64_d, minTick_q, minTick_d;
   logic secWr, minWr, hourWr;

   always_comb
   begin
      magnitude = offsetValue[rtcf_pkg::SIGN_BIT] ? 7'(-offsetValue) : offsetValue;
      if (magnitude == 7'd0)
         magnitude = offsetValue; // reached only by zero offset; -64 already negates to itself as 64
      secBin = bcdToBin(sec_q);
      minBin = bcdToBin(min_q);
      cycleMinute = fastMode && (offsetValue != 7'd0) && (minBin % rtcf_pkg::CYCLE_MINUTES == 0);
      pulses = 3'd0;
      if (cycleMinute)
      begin
         if (magnitude <= rtcf_pkg::SINGLE_MAX)
            pulses = (secBin < magnitude) ? 3'd1 : 3'd0;
         else if (secBin < rtcf_pkg::LAST_SECOND)
            pulses = 3'd1;
         else if (secBin == rtcf_pkg::LAST_SECOND)
            pulses = 3'(magnitude - rtcf_pkg::LAST_SECOND);
      end
      secLen = offsetValue[rtcf_pkg::SIGN_BIT] ? 11'(rtcf_pkg::TICKS_PER_SEC + pulses)
                                               : 11'(rtcf_pkg::TICKS_PER_SEC - pulses);
      secEnd = tickEvt && (tick_q >= 11'(secLen - 11'd1));
      tick_d = tickEvt ? (secEnd ? 11'd0 : 11'(tick_q + 11'd1)) : tick_q;
      intPulse_d = correctionEventEnable && (tick_q < 11'(pulses * rtcf_pkg::PULSE_SPACING_TICKS))
                   && !tick_q[0];
      oneHz_d = tick_q < rtcf_pkg::HALF_SEC_TICKS;
      hz64_d = tick_q[rtcf_pkg::HZ64_BIT];
      minTick_d = secEnd && (sec_q == rtcf_pkg::LAST_SEC_BCD);
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         tick_q <= 11'd0;
         intPulse_q <= 1'b0;
         oneHz_q <= 1'b0;
         hz64_q <= 1'b0;
         minTick_q <= 1'b0;
      end
      else
      begin
         tick_q <= tick_d;
         intPulse_q <= intPulse_d;
         oneHz_q <= oneHz_d;
         hz64_q <= hz64_d;
         minTick_q <= minTick_d;
      end
   end

   assign intOut = 1'b0;
   assign intOe = intPulse_q;
   assign oneHzOut = oneHz_q;
   assign timer64Hz = hz64_q;
   assign minuteTick = minTick_q;

   // time and scratch registers
   logic [7:0] scratch_q, scratch_d;
   logic osFlag_q, osFlag_d;
   logic [4:0] hr12;
   logic [6:0] hourInc24, hourInc12;
   logic secCarry, minCarry;

   always_comb
   begin
      secWr = regWrEn && (regAddr == rtcf_pkg::ADDR_SECONDS);
      minWr = regWrEn && (regAddr == rtcf_pkg::ADDR_MINUTES);
      hourWr = regWrEn && (regAddr == rtcf_pkg::ADDR_HOURS);
      scratch_d = (regWrEn && regAddr == rtcf_pkg::ADDR_SCRATCH) ? regWrData : scratch_q;
      osFlag_d = stopped_q || (secWr ? regWrData[rtcf_pkg::OS_BIT] : osFlag_q);
      secCarry = secEnd && (sec_q == rtcf_pkg::LAST_SEC_BCD);
      minCarry = secCarry && (min_q == rtcf_pkg::LAST_SEC_BCD);
      sec_d = sec_q;
      if (secWr)
         sec_d = regWrData[6:0];
      else if (secEnd)
         sec_d = secCarry ? 7'd0 : bcdInc(sec_q);
      min_d = min_q;
      if (minWr)
         min_d = regWrData[6:0];
      else if (secCarry)
         min_d = minCarry ? 7'd0 : bcdInc(min_q);
      hr12 = hour_q[4:0];
      hourInc24 = bcdInc({1'b0, hour_q});
      hourInc12 = bcdInc({2'b00, hr12});
      hour_d = hour_q;
      if (hourWr)
         hour_d = hourFormat12 ? regWrData[5:0] : {regWrData[5:4], regWrData[3:0]};
      else if (minCarry)
      begin
         if (!hourFormat12)
            hour_d = ({1'b0, hour_q} == rtcf_pkg::LAST_HOUR24_BCD) ? 6'd0 : hourInc24[5:0];
         else if (hr12 == rtcf_pkg::HOUR12_NOON_BCD)
            hour_d = {hour_q[rtcf_pkg::HALF_DAY_INDICATOR_BIT], rtcf_pkg::HOUR12_ONE_BCD};
         else if (hr12 == rtcf_pkg::HOUR12_ELEVEN_BCD)
            hour_d = {~hour_q[rtcf_pkg::HALF_DAY_INDICATOR_BIT], rtcf_pkg::HOUR12_NOON_BCD};
         else
            hour_d = {hour_q[rtcf_pkg::HALF_DAY_INDICATOR_BIT], hourInc12[4:0]};
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         scratch_q <= rtcf_pkg::RESET_SCRATCH;
         osFlag_q <= rtcf_pkg::RESET_OS;
         sec_q <= rtcf_pkg::RESET_SECONDS;
         min_q <= rtcf_pkg::RESET_MINUTES;
         hour_q <= rtcf_pkg::RESET_HOURS;
      end
      else
      begin
         scratch_q <= scratch_d;
         osFlag_q <= osFlag_d;
         sec_q <= sec_d;
         min_q <= min_d;
         hour_q <= hour_d;
      end
   end

   // register read
   logic [7:0] rdData_q, rdData_d;

   always_comb
   begin
      rdData_d = rdData_q;
      if (regRdEn)
      begin
         unique case (regAddr)
            rtcf_pkg::ADDR_SCRATCH: rdData_d = scratch_q;
            rtcf_pkg::ADDR_SECONDS: rdData_d = {osFlag_q, sec_q};
            rtcf_pkg::ADDR_MINUTES: rdData_d = {1'b0, min_q};
            rtcf_pkg::ADDR_HOURS: rdData_d = {2'b00, hour_q};
            default: rdData_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         rdData_q <= 8'h00;
      else
         rdData_q <= rdData_d;
   end

   assign regRdData = rdData_q;

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence secRollover;
      secEnd && !secWr && sec_q == rtcf_pkg::LAST_SEC_BCD;
   endsequence

   sequence plainTickEnd;
      tickEvt && !fastMode && tick_q == 11'd1023;
   endsequence

   a_os_sets_stop: assert property (stopped_q |=> osFlag_q) else $error("stop flag not set");
   a_os_holds_set: assert property (osFlag_q && !secWr |=> osFlag_q) else $error("stop flag dropped");
   a_scratch_write: assert property (regWrEn && regAddr == rtcf_pkg::ADDR_SCRATCH |=> scratch_q == $past(regWrData))
      else $error("scratch not stored");
   a_min_bit_zero: assert property (regRdEn && regAddr == rtcf_pkg::ADDR_MINUTES |=> !regRdData[7])
      else $error("minutes bit 7 set");
   a_hours_unused: assert property (regRdEn && regAddr == rtcf_pkg::ADDR_HOURS |=> regRdData[7:6] == 2'b00)
      else $error("hours unused bits set");
   a_pulse_place: assert property (intOe |-> !$past(tick_q[0]) && $past(tick_q) < 11'd10)
      else $error("pulse outside slot");
   a_pulse_count: assert property (pulses <= 3'd5) else $error("too many pulses");
   a_sec_wrap: assert property (secRollover |=> sec_q == 7'h00 ##0 minTick_q) else $error("seconds wrap");
   a_plain_second: assert property (plainTickEnd |=> tick_q == 11'd0) else $error("second length");
   a_hour24_wrap: assert property (minCarry && !hourWr && !hourFormat12 && hour_q == 6'h23 |=> hour_q == 6'h00)
      else $error("hour wrap");
endmodule
`default_nettype wire

// [shared/rtcf_pkg.sv]
`default_nettype none
package rtcf_pkg;
   // register addresses
   localparam logic [7:0] ADDR_SCRATCH = 8'h03;
   localparam logic [7:0] ADDR_SECONDS = 8'h04;
   localparam logic [7:0] ADDR_MINUTES = 8'h05;
   localparam logic [7:0] ADDR_HOURS = 8'h06;
   // field positions and reset values
   localparam int OS_BIT = 7;
   localparam int HALF_DAY_INDICATOR_BIT = 5;
   localparam int SIGN_BIT = 6;
   localparam logic [7:0] RESET_SCRATCH = 8'h00;
   localparam logic [6:0] RESET_SECONDS = 7'h00;
   localparam logic [6:0] RESET_MINUTES = 7'h00;
   localparam logic [5:0] RESET_HOURS = 6'h00;
   localparam logic RESET_OS = 1'b1;
   // bcd limits
   localparam logic [6:0] LAST_SEC_BCD = 7'h59;
   localparam logic [6:0] LAST_HOUR24_BCD = 7'h23;
   localparam logic [4:0] HOUR12_NOON_BCD = 5'h12;
   localparam logic [4:0] HOUR12_ELEVEN_BCD = 5'h11;
   localparam logic [4:0] HOUR12_ONE_BCD = 5'h01;
   // fast correction figures
   localparam int CYCLE_MINUTES = 4;
   localparam logic [6:0] SINGLE_MAX = 7'd60;
   localparam logic [6:0] LAST_SECOND = 7'd59;
   localparam int PULSE_SPACING_TICKS = 2;
   // time base
   localparam int LINK_HZ = 32768;
   localparam int TICK_HZ = 1024;
   localparam int LINK_DIV = LINK_HZ / TICK_HZ;
   localparam int DIV4096_BIT = 2;
   localparam logic [10:0] TICKS_PER_SEC = 11'd1024;
   localparam logic [10:0] HALF_SEC_TICKS = 11'd512;
   localparam int HZ64_BIT = 3;
   // oscillator stop watchdog: two tick periods
   localparam int CLK_PERIOD_NS = 5;
   localparam int OSC_STOP_NS = 1953125;
   localparam int OSC_STOP_CYCLES = OSC_STOP_NS / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// [bench/rtcf_crystal.sv]
`timescale 1ns/1ps
`default_nettype none
module rtcf_crystal (
   input wire logic run,
   output logic linkClk
);
   // free phase against the system clock; level holds while stopped
   initial
   begin
      linkClk = 1'b0;
      #13.7;
      forever
      begin
         #80;
         if (run)
            linkClk = ~linkClk;
      end
   end
endmodule
`default_nettype wire

// [bench/rtc_fast_correction_time_regs_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module rtc_fast_correction_time_regs_bench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic run = 1'b1;
   logic regWrEn = 1'b0;
   logic regRdEn = 1'b0;
   logic fastMode = 1'b0;
   logic correction_event_enable = 1'b0;
   logic hour12 = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWrData = 8'h00;
   logic [6:0] offsetValue = 7'h00;
   logic linkClk;
   logic [7:0] regRdData;
   logic intOut, intOe, oneHzOut, timer64Hz, minuteTick, timer4096Hz;
   int nMismatch = 0;
   int checked = 0;
   int cycles = 0;
   int seed = 40;
   logic [6:0] offs [8] = '{7'h01, 7'h40, 7'h3f, 7'h7f, 7'h00, 7'h05, 7'h05, 7'h3d};
   logic cies [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
   logic fms [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
   logic [7:0] secs [8] = '{8'h00, 8'h59, 8'h59, 8'h00, 8'h00, 8'h00, 8'h00, 8'h59};
   logic [7:0] mins [8] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00};

   rtcf_crystal rtcf_crystal_inst (.run(run), .linkClk(linkClk));
   rtcf_core #(.STOP_CYCLES(3000)) rtcf_core_inst (.clk(clk), .rst_n(rst_n), .linkClk(linkClk),
      .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
      .regRdData(regRdData), .offsetValue(offsetValue), .fastMode(fastMode),
      .correctionEventEnable(correction_event_enable), .hourFormat12(hour12), .intOut(intOut), .intOe(intOe),
      .oneHzOut(oneHzOut), .timer64Hz(timer64Hz), .minuteTick(minuteTick),
      .timer4096Hz(timer4096Hz));

   always #2.5 clk = ~clk;

   task stop_test;
      if (nMismatch == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 100000)
      begin
         nMismatch++;
         stop_test();
      end
   end

   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         nMismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(negedge clk);
      regWrEn = 1'b0;
   endtask

   task rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(negedge clk);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge clk);
      regRdEn = 1'b0;
      check(what, {24'h0, regRdData}, {24'h0, exp});
   endtask

   // long enough for the link domain to see several crystal edges
   task do_reset;
      @(negedge clk);
      rst_n = 1'b0;
      repeat (100) @(negedge clk);
      rst_n = 1'b1;
   endtask

   // pulses seen in the first nine ticks, and width of the last one
   task count_pulses(output int n, output int w);
      logic prev;
      n = 0;
      w = 0;
      prev = 1'b0;
      repeat (9600)
      begin
         @(posedge clk);
         #1;
         if (intOe === 1'b1 && prev !== 1'b1)
         begin
            n++;
            w = 0;
         end
         if (intOe === 1'b1)
            w++;
         prev = intOe;
      end
   endtask

   // pulses in the current second, from magnitude, bcd second and bcd minute
   function automatic int exp_pulses(input logic [6:0] off, input logic en, input logic fm,
      input logic [7:0] sec, input logic [7:0] mnt);
      int mag, s, m;
      mag = off[6] ? 128 - int'(off) : int'(off);
      s = 10 * int'(sec[6:4]) + int'(sec[3:0]);
      m = 10 * int'(mnt[6:4]) + int'(mnt[3:0]);
      if (!fm || !en || mag == 0 || m % 4 != 0)
         return 0;
      if (mag <= 60)
         return (s < mag) ? 1 : 0;
      return (s < 59) ? 1 : mag - 59;
   endfunction

   initial
   begin
      logic [7:0] v;
      int n, w, t;
      do_reset();
      rd(rtcf_pkg::ADDR_SCRATCH, rtcf_pkg::RESET_SCRATCH, "scratch reset");
      rd(rtcf_pkg::ADDR_SECONDS, 8'h80, "seconds reset");
      rd(rtcf_pkg::ADDR_MINUTES, 8'h00, "minutes reset");
      rd(rtcf_pkg::ADDR_HOURS, 8'h00, "hours reset");
      rd(8'h0b, 8'h00, "unmapped");
      repeat (4)
      begin
         v = 8'($random(seed));
         wr(rtcf_pkg::ADDR_SCRATCH, v);
         rd(rtcf_pkg::ADDR_SCRATCH, v, "scratch");
      end
      wr(rtcf_pkg::ADDR_MINUTES, 8'hd7);
      rd(rtcf_pkg::ADDR_MINUTES, 8'h57, "minutes");
      wr(rtcf_pkg::ADDR_HOURS, 8'he3);
      rd(rtcf_pkg::ADDR_HOURS, 8'h23, "hours 24");
      hour12 = 1'b1;
      wr(rtcf_pkg::ADDR_HOURS, 8'h31);
      rd(rtcf_pkg::ADDR_HOURS, 8'h31, "hours 12");
      repeat (2048) @(negedge clk);
      wr(rtcf_pkg::ADDR_SECONDS, 8'h25);
      rd(rtcf_pkg::ADDR_SECONDS, 8'h25, "stop flag cleared");
      run = 1'b0;
      repeat (4000) @(negedge clk);
      rd(rtcf_pkg::ADDR_SECONDS, 8'ha5, "stop flag set");
      wr(rtcf_pkg::ADDR_SECONDS, 8'h25);
      rd(rtcf_pkg::ADDR_SECONDS, 8'ha5, "stop flag held");
      run = 1'b1;
      repeat (3000) @(negedge clk);
      wr(rtcf_pkg::ADDR_SECONDS, 8'h25);
      rd(rtcf_pkg::ADDR_SECONDS, 8'h25, "stop flag recleared");
      t = 0;
      @(negedge linkClk);
      v[0] = timer4096Hz;
      repeat (64)
      begin
         @(negedge linkClk);
         if (timer4096Hz !== v[0])
            t++;
         v[0] = timer4096Hz;
      end
      check("fast timer toggles", t, 16);
      for (int i = 0; i < 8; i++)
      begin
         @(negedge clk);
         offsetValue = offs[i];
         correction_event_enable = 1'b0;
         fastMode = fms[i];
         do_reset();
         wr(rtcf_pkg::ADDR_SECONDS, secs[i]);
         wr(rtcf_pkg::ADDR_MINUTES, mins[i]);
         @(negedge clk);
         correction_event_enable = cies[i];
         count_pulses(n, w);
         check("pulse count", n, exp_pulses(offs[i], cies[i], fms[i], secs[i], mins[i]));
         if (n > 1)
            check("pulse width", 32'(w >= 1020 && w <= 1028), 1);
         check("one hz level", {31'h0, oneHzOut}, 1);
         check("timer 64 Hz", {31'h0, timer64Hz}, 1);
         check("interrupt data", {31'h0, intOut}, 0);
      end
      stop_test();
   end
endmodule
`default_nettype wire
